// file: rtl/mbr_pkg.sv
// Constants shared by the bank 0 operation register block.
// Assumes a 32-bit APB slave with one register per aligned word.
package mbr_pkg;
  localparam logic [11:0] OFF_INDIRECT = 12'h000;
  localparam logic [11:0] OFF_TIMER = 12'h004;
  localparam logic [11:0] OFF_PC_LOW = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_RAM_SEL = 12'h010;
  localparam logic [11:0] OFF_DATA_LINE = 12'h014;
  localparam logic [11:0] OFF_PORT6 = 12'h018;
  localparam logic [11:0] OFF_PORT7 = 12'h01C;
  localparam logic [11:0] OFF_WAKE6 = 12'h020;
  localparam logic [11:0] OFF_WAKE7 = 12'h024;
  localparam logic [11:0] OFF_HIGH_PAT = 12'h028;
  localparam logic [11:0] OFF_LOW_PAT = 12'h02C;
  localparam logic [11:0] OFF_CONTROL = 12'h040;
  localparam logic [11:0] OFF_PC_FULL = 12'h044;
  localparam logic [11:0] OFF_EVENT = 12'h048;
  localparam logic [11:0] OFF_EVENT_EN = 12'h04C;
  localparam logic [11:0] OFF_EVENT_CLR = 12'h050;
  localparam logic [11:0] OFF_RAM_WINDOW = 12'h100;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_STATUS = 8'h18;
  localparam logic [7:0] RESET_WAKE = 8'hFF;
  localparam logic [10:0] RESET_PC = 11'h000;
  localparam int BIT_CARRY = 0;
  localparam int BIT_HALF_CARRY = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_TIME_OUT = 4;
  localparam int BIT_PAGE = 5;
  localparam int BIT_GP = 6;
  localparam int BIT_SPECIAL_BANK = 7;
  localparam int CTRL_KEYBOARD_MODE = 0;
  localparam int CTRL_PATTERN_EN = 1;
  localparam int EV_WAKE = 0;
  localparam int EV_TIME_OUT = 1;
  localparam int EV_TIMER_WRAP = 2;
  localparam int EV_WIDTH = 3;
  localparam int RAM_WORDS = 128;
endpackage

// file: rtl/mbr_wake_detect.sv
// Per-pin change detector for wake-up from sleep.
// Assumes pin inputs are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module mbr_wake_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] pins,
  input wire logic [7:0] wake_disable,
  input wire logic sleeping,
  output logic wake
);
  logic [7:0] last_pins;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pins <= 8'h00;
    end else begin
      last_pins <= pins;
    end
  end

  // A cleared select bit arms the pin; any change while asleep wakes the core.
  assign wake = sleeping && (((pins ^ last_pins) & ~wake_disable) != 8'h00);
endmodule
`default_nettype wire

// file: rtl/mbr_bank0_regs.sv
// Bank 0 operation registers of an 8-bit core, reached over APB.
// Assumes the core reports arithmetic flags and power events as one-cycle pulses.
// Functional notes
// R01: Indirect location has no storage; accesses go to RAM at the select address.
// R02: Timer register is 8 bits, read/write, zero after any reset.
// R03: Program counter is 11 bits, clears on reset, starts at 00h.
// R04: Status bit 0 is carry, bit 1 half carry from arithmetic.
// R05: Status bit 2 is set when a result is zero.
// R06: Power-down flag set at power-on or watchdog clear, cleared entering power-down.
// R07: Time-out flag set at power-on or watchdog clear, cleared by watchdog time-out.
// R08: After power-down or pin wake-up, time-out reads 1 and power-down 0.
// R09: Status bit 5 selects program page 0000-03FF or 0400-07FF.
// R10: Status bit 7 selects primary or alternate special register bank.
// R11: Status bit 6 is plain storage.
// R12: Select bits 5:0 address 00-3F; 00-1F is common to all banks.
// R13: Select bits 7:6 pick bank 0, 1, 2 above 1F; 11 undefined.
// R14: Data-line bits 1:0 follow the lines, accessible only in keyboard mode.
// R15: Data-line bits 7:2 are plain storage.
// R16: Port 6 wake select bit 0 arms pin wake-up from sleep.
// R17: Port 7 wake select behaves the same for its eight pins.
// R18: Pattern counters serve pattern detect, else plain storage.
// R19: Port writes load output latches; reads return pin states.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mbr_bank0_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_reset,
  input wire logic watchdog_clear_instr,
  input wire logic power_down_enter,
  input wire logic watchdog_timeout,
  input wire logic alu_update,
  input wire logic alu_carry,
  input wire logic alu_half_carry,
  input wire logic alu_zero,
  input wire logic timer_tick,
  input wire logic pc_advance,
  input wire logic [7:0] port6_pin,
  input wire logic [7:0] port7_pin,
  input wire logic [1:0] data_line_in,
  input wire logic pattern_high_tick,
  input wire logic pattern_low_tick,
  output logic [7:0] port6_latch,
  output logic [7:0] port7_latch,
  output logic [1:0] data_line_out,
  output logic [10:0] program_counter,
  output logic program_page_select,
  output logic special_bank_select,
  output logic sleeping,
  output logic wake_up,
  output logic irq
);
  logic [7:0] timer_counter_reg;
  logic [7:0] status_reg;
  logic [7:0] ram_select_reg;
  logic [7:0] data_line_reg;
  logic [7:0] port6_wake_disable;
  logic [7:0] port7_wake_disable;
  logic [7:0] high_pattern_count;
  logic [7:0] low_pattern_count;
  logic [1:0] control;
  logic [mbr_pkg::EV_WIDTH-1:0] event_status;
  logic [mbr_pkg::EV_WIDTH-1:0] event_enable;
  logic [7:0] ram [mbr_pkg::RAM_WORDS];
  logic wake6;
  logic wake7;
  logic [7:0] next_rdata;

  wire logic wr = psel && penable && pwrite;
  wire logic rd_phase = psel && !penable;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    hit = (addr == off);
  endfunction

  // Maps a select-register value to a RAM row: low 32 common, then three 32-word banks.
  function automatic logic [6:0] ram_row(input logic [7:0] sel);
    if (!sel[5]) begin
      ram_row = {2'b00, sel[4:0]};
    end else begin
      ram_row = {sel[7:6] + 2'b01, sel[4:0]};
    end
  endfunction

  wire logic [6:0] ind_row = ram_row(ram_select_reg);
  wire logic ind_valid = !(ram_select_reg[5] && ram_select_reg[7:6] == 2'b11);
  // The window holds one word per select value, so it reaches well past its first 256 bytes.
  wire logic [11:0] win_off = paddr - mbr_pkg::OFF_RAM_WINDOW;
  wire logic [6:0] win_row = ram_row(win_off[9:2]);
  wire logic win_hit = paddr >= mbr_pkg::OFF_RAM_WINDOW && win_off[11:10] == 2'b00;
  wire logic win_valid = !(win_off[7] && win_off[9:8] == 2'b11);

  mbr_wake_detect u_wake6 (
    .pclk(pclk),
    .presetn(presetn),
    .pins(port6_pin),
    .wake_disable(port6_wake_disable),
    .sleeping(sleeping),
    .wake(wake6)
  );

  mbr_wake_detect u_wake7 (
    .pclk(pclk),
    .presetn(presetn),
    .pins(port7_pin),
    .wake_disable(port7_wake_disable),
    .sleeping(sleeping),
    .wake(wake7)
  );

  // R01 indirect RAM access
  // R12 common low space
  // R13 bank select above 1F
  always_ff @(posedge pclk) begin
    if (wr && hit(paddr, mbr_pkg::OFF_INDIRECT) && ind_valid) begin
      ram[ind_row] <= pwdata[7:0];
    end else if (wr && win_hit && win_valid) begin
      ram[win_row] <= pwdata[7:0];
    end
  end

  // R02 timer register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_counter_reg <= mbr_pkg::RESET_ZERO;
    end else if (watchdog_reset) begin
      timer_counter_reg <= mbr_pkg::RESET_ZERO;
    end else if (wr && hit(paddr, mbr_pkg::OFF_TIMER)) begin
      timer_counter_reg <= pwdata[7:0];
    end else if (timer_tick) begin
      timer_counter_reg <= timer_counter_reg + 8'h01;
    end
  end

  // R03 program counter reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter <= mbr_pkg::RESET_PC;
    end else if (watchdog_reset) begin
      program_counter <= mbr_pkg::RESET_PC;
    end else if (wr && hit(paddr, mbr_pkg::OFF_PC_LOW)) begin
      program_counter <= {program_counter[10:8], pwdata[7:0]};
    end else if (wr && hit(paddr, mbr_pkg::OFF_PC_FULL)) begin
      program_counter <= pwdata[10:0];
    end else if (pc_advance && !sleeping) begin
      program_counter <= program_counter + 11'h001;
    end
  end

  // Sleep lasts from power-down entry until a pin wake or watchdog reset; the PC holds meanwhile.
  // R16 port 6 wake
  // R17 port 7 wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
      wake_up <= 1'b0;
    end else begin
      wake_up <= wake6 || wake7;
      if (power_down_enter) begin
        sleeping <= 1'b1;
      end else if (wake6 || wake7 || watchdog_reset) begin
        sleeping <= 1'b0;
      end
    end
  end

  // Software writes carry, half carry, zero, page, gp and bank bits; hardware owns 4:3.
  // R04 carry flags
  // R05 zero flag
  // R06 power-down flag
  // R07 time-out flag
  // R08 power-down flag pair
  // R09 page select
  // R10 special bank
  // R11 storage bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= mbr_pkg::RESET_STATUS;
    end else begin
      if (wr && hit(paddr, mbr_pkg::OFF_STATUS)) begin
        status_reg[2:0] <= pwdata[2:0];
        status_reg[7:5] <= pwdata[7:5];
      end
      if (alu_update) begin
        status_reg[mbr_pkg::BIT_CARRY] <= alu_carry;
        status_reg[mbr_pkg::BIT_HALF_CARRY] <= alu_half_carry;
        status_reg[mbr_pkg::BIT_ZERO] <= alu_zero;
      end
      if (watchdog_clear_instr) begin
        status_reg[mbr_pkg::BIT_POWER_DOWN] <= 1'b1;
        status_reg[mbr_pkg::BIT_TIME_OUT] <= 1'b1;
      end else if (watchdog_timeout) begin
        status_reg[mbr_pkg::BIT_TIME_OUT] <= 1'b0;
      end else if (power_down_enter) begin
        status_reg[mbr_pkg::BIT_POWER_DOWN] <= 1'b0;
        status_reg[mbr_pkg::BIT_TIME_OUT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_select_reg <= mbr_pkg::RESET_ZERO;
      control <= 2'b00;
      port6_wake_disable <= mbr_pkg::RESET_WAKE;
      port7_wake_disable <= mbr_pkg::RESET_WAKE;
    end else if (wr) begin
      if (hit(paddr, mbr_pkg::OFF_RAM_SEL)) begin
        ram_select_reg <= pwdata[7:0];
      end
      if (hit(paddr, mbr_pkg::OFF_CONTROL)) begin
        control <= pwdata[1:0];
      end
      if (hit(paddr, mbr_pkg::OFF_WAKE6)) begin
        port6_wake_disable <= pwdata[7:0];
      end
      if (hit(paddr, mbr_pkg::OFF_WAKE7)) begin
        port7_wake_disable <= pwdata[7:0];
      end
    end
  end

  // R14 line bits keyboard only
  // R15 upper storage bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_line_reg <= mbr_pkg::RESET_ZERO;
    end else if (wr && hit(paddr, mbr_pkg::OFF_DATA_LINE)) begin
      data_line_reg[7:2] <= pwdata[7:2];
      if (control[mbr_pkg::CTRL_KEYBOARD_MODE]) begin
        data_line_reg[1:0] <= pwdata[1:0];
      end
    end
  end

  // R19 port output latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port6_latch <= mbr_pkg::RESET_ZERO;
      port7_latch <= mbr_pkg::RESET_ZERO;
    end else if (wr && hit(paddr, mbr_pkg::OFF_PORT6)) begin
      port6_latch <= pwdata[7:0];
    end else if (wr && hit(paddr, mbr_pkg::OFF_PORT7)) begin
      port7_latch <= pwdata[7:0];
    end
  end

  // Counting only runs with pattern detect on; a write always wins.
  // R18 pattern counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_pattern_count <= mbr_pkg::RESET_ZERO;
      low_pattern_count <= mbr_pkg::RESET_ZERO;
    end else begin
      if (wr && hit(paddr, mbr_pkg::OFF_HIGH_PAT)) begin
        high_pattern_count <= pwdata[7:0];
      end else if (control[mbr_pkg::CTRL_PATTERN_EN] && pattern_high_tick) begin
        high_pattern_count <= high_pattern_count + 8'h01;
      end
      if (wr && hit(paddr, mbr_pkg::OFF_LOW_PAT)) begin
        low_pattern_count <= pwdata[7:0];
      end else if (control[mbr_pkg::CTRL_PATTERN_EN] && pattern_low_tick) begin
        low_pattern_count <= low_pattern_count + 8'h01;
      end
    end
  end

  // Events set over a clear in the same cycle, so none is lost.
  wire logic [mbr_pkg::EV_WIDTH-1:0] ev_set =
    {timer_tick && timer_counter_reg == 8'hFF, watchdog_timeout, wake6 || wake7};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= '0;
      event_enable <= '0;
      irq <= 1'b0;
    end else begin
      if (wr && hit(paddr, mbr_pkg::OFF_EVENT_CLR)) begin
        event_status <= (event_status & ~pwdata[mbr_pkg::EV_WIDTH-1:0]) | ev_set;
      end else begin
        event_status <= event_status | ev_set;
      end
      if (wr && hit(paddr, mbr_pkg::OFF_EVENT_EN)) begin
        event_enable <= pwdata[mbr_pkg::EV_WIDTH-1:0];
      end
      irq <= ((event_status | ev_set) & event_enable) != '0;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    unique case (paddr)
      mbr_pkg::OFF_INDIRECT: next_rdata = ind_valid ? ram[ind_row] : 8'h00;
      mbr_pkg::OFF_TIMER: next_rdata = timer_counter_reg;
      mbr_pkg::OFF_PC_LOW: next_rdata = program_counter[7:0];
      mbr_pkg::OFF_STATUS: next_rdata = status_reg;
      mbr_pkg::OFF_RAM_SEL: next_rdata = ram_select_reg;
      mbr_pkg::OFF_DATA_LINE: next_rdata = {data_line_reg[7:2],
        control[mbr_pkg::CTRL_KEYBOARD_MODE] ? data_line_in : 2'b00};
      mbr_pkg::OFF_PORT6: next_rdata = port6_pin;
      mbr_pkg::OFF_PORT7: next_rdata = port7_pin;
      mbr_pkg::OFF_WAKE6: next_rdata = port6_wake_disable;
      mbr_pkg::OFF_WAKE7: next_rdata = port7_wake_disable;
      mbr_pkg::OFF_HIGH_PAT: next_rdata = high_pattern_count;
      mbr_pkg::OFF_LOW_PAT: next_rdata = low_pattern_count;
      mbr_pkg::OFF_CONTROL: next_rdata = {6'h00, control};
      mbr_pkg::OFF_PC_FULL: next_rdata = program_counter[7:0];
      mbr_pkg::OFF_EVENT: next_rdata = {5'h00, event_status};
      mbr_pkg::OFF_EVENT_EN: next_rdata = {5'h00, event_enable};
      default: next_rdata = (win_hit && win_valid) ? ram[win_row] : 8'h00;
    endcase
  end

  // Read data is captured in the setup cycle so the access phase answers at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_phase;
      pslverr <= 1'b0;
      if (rd_phase && !pwrite) begin
        prdata <= {21'h0, hit(paddr, mbr_pkg::OFF_PC_FULL) ?
          program_counter[10:8] : 3'h0, next_rdata};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_line_out <= 2'b00;
      program_page_select <= 1'b0;
      special_bank_select <= 1'b0;
    end else begin
      data_line_out <= data_line_reg[1:0];
      program_page_select <= status_reg[mbr_pkg::BIT_PAGE];
      special_bank_select <= status_reg[mbr_pkg::BIT_SPECIAL_BANK];
    end
  end

  a_timer_wd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_reset |=> timer_counter_reg == 8'h00) // R02
    else $error("timer not cleared by watchdog reset");
  a_pc_wd_clear: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_reset |=> program_counter == 11'h000) // R03
    else $error("program counter not cleared");
  a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
    alu_update |=> status_reg[2] == $past(alu_zero)) // R05
    else $error("zero flag wrong");
  a_pd_flag_pair: assert property (@(posedge pclk) disable iff (!presetn)
    power_down_enter && !watchdog_clear_instr && !watchdog_timeout
    |=> status_reg[4:3] == 2'b10) // R08
    else $error("power-down flag pair wrong");
  a_timeout_flag: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_timeout && !watchdog_clear_instr |=> !status_reg[4]) // R07
    else $error("time-out flag not cleared");
  a_wdclear_flags: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_clear_instr |=> status_reg[4:3] == 2'b11) // R06
    else $error("watchdog clear did not set flags");
  a_wake_armed: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && ((port6_pin ^ $past(port6_pin)) & ~port6_wake_disable) != 8'h00
    && !power_down_enter |=> !sleeping) // R16
    else $error("armed pin did not wake");
  a_line_guard: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, mbr_pkg::OFF_DATA_LINE) && !control[0]
    |=> $stable(data_line_reg[1:0])) // R14
    else $error("line bits written outside keyboard mode");
  a_pattern_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !control[1] && !(wr && hit(paddr, mbr_pkg::OFF_HIGH_PAT))
    |=> $stable(high_pattern_count)) // R18
    else $error("pattern counter moved while disabled");
  c_wake: cover property (@(posedge pclk) disable iff (!presetn) sleeping ##1 !sleeping);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_ind_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, mbr_pkg::OFF_INDIRECT));
endmodule
`default_nettype wire

// file: sim/test_mbr_bank0_regs.sv
// Self-checking bench for the bank 0 operation register block.
// Assumes the block answers APB in one access cycle and takes one-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none
module test_mbr_bank0_regs;
  localparam int P_WRST = 0, P_WCLR = 1, P_PD = 2, P_WTO = 3, P_ALU = 4;
  localparam int P_TICK = 5, P_PC = 6, P_HT = 7, P_LT = 8;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sleeping, wake_up, irq, pps, sbs;
  logic [8:0] pul;
  logic alu_c, alu_h, alu_z;
  logic [7:0] p6_pin, p7_pin, p6_lat, p7_lat, v, w, sv;
  logic [1:0] dl_in, dl_out;
  logic [10:0] pc;
  int n_fail, total_checks, cycles, wakes, k;
  logic [11:0] ra [11] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014, 12'h020, 12'h024,
    12'h028, 12'h02C, 12'h048, 12'h04C};
  logic [7:0] rv [11] = '{8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00,
    8'h00, 8'h00};

  mbr_bank0_regs mbr_bank0_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_reset(pul[P_WRST]),
    .watchdog_clear_instr(pul[P_WCLR]), .power_down_enter(pul[P_PD]),
    .watchdog_timeout(pul[P_WTO]), .alu_update(pul[P_ALU]), .alu_carry(alu_c),
    .alu_half_carry(alu_h), .alu_zero(alu_z), .timer_tick(pul[P_TICK]),
    .pc_advance(pul[P_PC]), .port6_pin(p6_pin), .port7_pin(p7_pin), .data_line_in(dl_in),
    .pattern_high_tick(pul[P_HT]), .pattern_low_tick(pul[P_LT]), .port6_latch(p6_lat),
    .port7_latch(p7_lat), .data_line_out(dl_out), .program_counter(pc),
    .program_page_select(pps), .special_bank_select(sbs), .sleeping(sleeping),
    .wake_up(wake_up), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // The ceiling is far above the few hundred cycles the sequence needs.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (wake_up === 1'b1) wakes <= wakes + 1;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request is held until pready is seen high at an edge, then released.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    check({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, {24'h0, e});
  endtask

  task automatic pulse(input int i);
    pul[i] <= 1'b1;
    @(posedge pclk);
    pul[i] <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Status as software wrote it, with the last arithmetic flags and the given flag pair.
  function automatic logic [7:0] status_exp(input logic [7:0] flags);
    status_exp = (sv & 8'hE0) | flags | {5'h0, alu_z, alu_h, alu_c};
  endfunction

  initial begin
    {presetn, psel, penable, pwrite, alu_c, alu_h, alu_z} = '0;
    paddr = '0;
    pwdata = '0;
    pul = '0;
    p6_pin = '0;
    p7_pin = '0;
    dl_in = '0;
    {n_fail, total_checks, cycles, wakes} = '0;
    void'($urandom(32'h816ce7d0));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 11; i++) rchk(ra[i], rv[i]);
    rchk(12'hFFC, 8'h00);
    done("reset");
    sv = 8'($urandom);
    wr(mbr_pkg::OFF_STATUS, sv);
    rchk(mbr_pkg::OFF_STATUS, (sv & 8'hE7) | 8'h18);
    check({30'h0, sbs, pps}, {30'h0, sv[7], sv[5]});
    for (int i = 0; i < 4; i++) begin
      {alu_z, alu_h, alu_c} <= 3'($urandom);
      pulse(P_ALU);
      rchk(mbr_pkg::OFF_STATUS, status_exp(8'h18));
    end
    done("status");
    wr(mbr_pkg::OFF_RAM_SEL, 8'h0C);
    wr(mbr_pkg::OFF_INDIRECT, 8'hA5);
    wr(mbr_pkg::OFF_RAM_SEL, 8'h4C);
    rchk(mbr_pkg::OFF_INDIRECT, 8'hA5);
    for (int i = 0; i < 3; i++) begin
      wr(mbr_pkg::OFF_RAM_SEL, {2'(i), 6'h3C});
      wr(mbr_pkg::OFF_INDIRECT, 8'h30 + 8'(i));
    end
    wr(mbr_pkg::OFF_RAM_SEL, 8'h3C);
    rchk(mbr_pkg::OFF_INDIRECT, 8'h30);
    rchk(mbr_pkg::OFF_RAM_WINDOW + 12'h1F0, 8'h31);
    wr(mbr_pkg::OFF_RAM_SEL, 8'hFC);
    rchk(mbr_pkg::OFF_INDIRECT, 8'h00);
    done("ram");
    wr(mbr_pkg::OFF_DATA_LINE, 8'hFF);
    rchk(mbr_pkg::OFF_DATA_LINE, 8'hFC);
    wr(mbr_pkg::OFF_CONTROL, 8'h01);
    dl_in <= 2'b01;
    wr(mbr_pkg::OFF_DATA_LINE, 8'h52);
    rchk(mbr_pkg::OFF_DATA_LINE, 8'h51);
    check({30'h0, dl_out}, 32'h2);
    v = 8'($urandom);
    w = 8'($urandom);
    p6_pin <= ~v;
    p7_pin <= w;
    wr(mbr_pkg::OFF_PORT6, v);
    wr(mbr_pkg::OFF_PORT7, ~w);
    check({16'h0, p6_lat, p7_lat}, {16'h0, v, ~w});
    rchk(mbr_pkg::OFF_PORT6, ~v);
    rchk(mbr_pkg::OFF_PORT7, w);
    done("lines and ports");
    wr(mbr_pkg::OFF_CONTROL, 8'h00);
    wr(mbr_pkg::OFF_HIGH_PAT, v);
    wr(mbr_pkg::OFF_LOW_PAT, w);
    pulse(P_HT);
    rchk(mbr_pkg::OFF_HIGH_PAT, v);
    wr(mbr_pkg::OFF_CONTROL, 8'h02);
    pulse(P_HT);
    pulse(P_LT);
    rchk(mbr_pkg::OFF_HIGH_PAT, v + 8'h01);
    rchk(mbr_pkg::OFF_LOW_PAT, w + 8'h01);
    done("pattern");
    k = $urandom_range(7);
    wr(mbr_pkg::OFF_WAKE6, ~(8'h01 << k));
    wr(mbr_pkg::OFF_EVENT_EN, 8'h01);
    pulse(P_PD);
    check({31'h0, sleeping}, 32'h1);
    rchk(mbr_pkg::OFF_STATUS, status_exp(8'h10));
    p6_pin <= p6_pin ^ ~(8'h01 << k);
    repeat (4) @(posedge pclk);
    check(wakes, 0);
    p6_pin <= p6_pin ^ (8'h01 << k);
    repeat (4) @(posedge pclk);
    check(wakes, 1);
    check({30'h0, irq, sleeping}, 32'h2);
    rchk(mbr_pkg::OFF_STATUS, status_exp(8'h10));
    wr(mbr_pkg::OFF_EVENT_CLR, 8'h01);
    // The interrupt line is registered, so it falls one edge after the clear lands.
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(mbr_pkg::OFF_WAKE7, 8'h7F);
    pulse(P_PD);
    p7_pin <= p7_pin ^ 8'h80;
    repeat (4) @(posedge pclk);
    check(wakes, 2);
    rchk(mbr_pkg::OFF_EVENT, 8'h01);
    done("wake");
    pulse(P_WTO);
    rchk(mbr_pkg::OFF_STATUS, status_exp(8'h00));
    wr(mbr_pkg::OFF_TIMER, 8'h5A);
    for (int i = 0; i < 3; i++) pulse(P_PC);
    check({21'h0, pc}, 32'h3);
    rchk(mbr_pkg::OFF_PC_FULL, 8'h03);
    pulse(P_WRST);
    check({21'h0, pc}, 32'h0);
    rchk(mbr_pkg::OFF_TIMER, 8'h00);
    apb(1'b0, mbr_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'h08, 32'h0);
    pulse(P_WCLR);
    apb(1'b0, mbr_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'h18, 32'h18);
    done("watchdog");
    wr(mbr_pkg::OFF_EVENT_EN, 8'h04);
    wr(mbr_pkg::OFF_TIMER, 8'hFF);
    pulse(P_TICK);
    rchk(mbr_pkg::OFF_TIMER, 8'h00);
    rchk(mbr_pkg::OFF_EVENT, 8'h07);
    check({31'h0, irq}, 32'h1);
    wr(mbr_pkg::OFF_EVENT_EN, 8'h00);
    @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    wr(mbr_pkg::OFF_EVENT_CLR, 8'h07);
    rchk(mbr_pkg::OFF_EVENT, 8'h00);
    done("timer event");
    finish_test();
  end
endmodule
`default_nettype wire
